// >>> ep_buf_tracker.sv
/*
 * Occupancy tracker for one multiple-buffered large endpoint.
 * Assumes done pulses come from logic on the same clock, one per packet.
 */
module ep_buf_tracker #(
  parameter int unsigned DEPTH_W = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic [DEPTH_W-1:0] depth_i,
  input wire logic dir_in_i,
  input wire logic flush_i,
  // Packet completions
  input wire logic usb_done_i,
  input wire logic ext_done_i,
  // Status
  output logic usb_ready_o,
  output logic ext_ready_o,
  output logic [DEPTH_W-1:0] occ_o
);
  logic [DEPTH_W-1:0] occ_r;
  logic [DEPTH_W-1:0] occ_nxt;
  logic fill;
  logic drain;

  // IN: external side fills, USB drains; OUT the other way round
  assign fill = dir_in_i ? ext_done_i : usb_done_i;
  assign drain = dir_in_i ? usb_done_i : ext_done_i;

  always_comb begin
    occ_nxt = occ_r;
    if (fill && !drain && occ_r < depth_i) begin
      occ_nxt = occ_r + 1'b1;
    end else if (drain && !fill && occ_r != '0) begin
      occ_nxt = occ_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      occ_r <= '0;
    end else begin
      occ_r <= occ_nxt;
    end
  end

  // Each side sees its own free or filled buffer independently
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      usb_ready_o <= 1'b0;
      ext_ready_o <= 1'b0;
    end else begin
      usb_ready_o <= dir_in_i ? (occ_nxt != '0) : (occ_nxt < depth_i); // RL17
      ext_ready_o <= dir_in_i ? (occ_nxt < depth_i) : (occ_nxt != '0); // RL17
    end
  end

  assign occ_o = occ_r;
endmodule

// >>> usb_endpoint_config_bank.sv
/*
 * Endpoint configuration bank with Wishbone slave, buffer pointer access,
 * token answer decision, payload limit check and large-endpoint trackers.
 * Assumes one clock; speed, token and done inputs are on that clock.
 */
// The Wishbone interface to the registers is this design's own decision.
// Contract
// RL1: Endpoints 0 and 1 are CPU-only 64-byte buffers, never externally tied.
// RL2: External logic connects only to large endpoints 2, 4, 6 and 8.
// RL3: Firmware reaches buffers as plain RAM or via auto-increment pointer.
// RL4: Payloads bounded: HS bulk 512, FS iso 1-1023, HS int/iso 1-1024.
// RL5: At full speed non-iso large buffers are 64 bytes; type, depth stay.
// RL6: Six consecutive byte registers configure endpoints 1 out/in, 2,4,6,8.
// RL7: Endpoint 1 fixed 64 bytes, single buffered; type only int or bulk.
// RL8: Sender never sends endpoint 1 packets larger than 64 bytes.
// RL9: Endpoint 0 always valid control, one shared 64-byte buffer.
// RL10: Endpoints 2, 6 size 512 or 1024 at HS; double, triple, quad.
// RL11: Endpoints 4, 8 fixed 512 double at HS, 64 double at FS; iso at FS keeps 512 here.
// RL12: Valid flag defaults set; clear means no answer to host tokens.
// RL13: Type bits 5:4: 00 invalid, 01 iso, 10 bulk default, 11 int.
// RL14: Large endpoint direction bit: one is IN, zero is OUT.
// RL15: Buffering bits on 2, 6: 00 quad, 01 invalid, 10 double, 11 triple.
// RL16: Buffer allocation by another endpoint overrides that endpoint's valid.
// RL17: USB side and external side work on different buffers concurrently.
// RL18: Firmware disables unused endpoints by clearing only the valid bit.
// RL19: Firmware waits a short delay between configuration writes.
module usb_endpoint_config_bank (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [usb_ep_cfg_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Link state
  input wire logic high_speed_i,
  // Host token
  input wire logic token_i,
  input wire logic [3:0] token_ep_i,
  input wire logic token_in_i,
  input wire logic [10:0] token_len_i,
  output logic answer_o,
  output logic ready_o,
  output logic len_ok_o,
  // Large endpoint packet completions, order 2, 4, 6, 8
  input wire logic [3:0] usb_done_i,
  input wire logic [3:0] ext_done_i,
  output logic [3:0] ext_ready_o,
  output logic [3:0] ext_enable_o,
  // Buffer RAM port
  output logic [15:0] buf_addr_o,
  output logic [7:0] buf_wdata_o,
  output logic buf_we_o,
  output logic buf_re_o,
  input wire logic [7:0] buf_rdata_i
);
  logic [7:0] cfg_r [usb_ep_cfg_pkg::NUM_CFG];
  logic [15:0] ptr_r;
  logic req_r;
  logic wait_r;
  logic [15:0] idx_r;
  logic data_rd_r;
  logic [7:0] reg_rd_r;
  logic take;
  logic [15:0] idx;
  logic [2:0] depth [4];
  logic [10:0] bsize [6];
  logic [5:0] enabled;
  logic [3:0] usb_ready;
  logic [3:0] large_in;
  logic cons_four;
  logic cons_six;
  logic cons_eight;
  logic [7:0] cfg_prev [4];
  logic [3:0] flush;
  logic [1:0] tok_n;
  logic [1:0] tok_t;
  logic [10:0] tok_lim;

  assign take = cyc_i && stb_i && !req_r && !wait_r && !ack_o;
  assign idx = adr_i[usb_ep_cfg_pkg::ADDR_W-1:2];

  // Map a register index to a slot, or 7 when unmapped
  function automatic logic [2:0] cfg_slot(input logic [15:0] i);
    if (i == usb_ep_cfg_pkg::IDX_EP1_OUT) begin
      return 3'h0;
    end else if (i == usb_ep_cfg_pkg::IDX_EP1_IN) begin
      return 3'h1;
    end else if (i == usb_ep_cfg_pkg::IDX_EP_TWO) begin
      return 3'h2;
    end else if (i == usb_ep_cfg_pkg::IDX_EP_FOUR) begin
      return 3'h3;
    end else if (i == usb_ep_cfg_pkg::IDX_EP_SIX) begin
      return 3'h4;
    end else if (i == usb_ep_cfg_pkg::IDX_EP_EIGHT) begin
      return 3'h5;
    end else begin
      return 3'h7;
    end
  endfunction

  // Fields a write may change depend on the endpoint's abilities
  function automatic logic [7:0] clean_cfg(input logic [2:0] s,
      input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] v;
    logic [1:0] t;
    logic [1:0] b;
    v = '0;
    t = wr[usb_ep_cfg_pkg::TYPE_LSB +: 2];
    b = wr[usb_ep_cfg_pkg::BUF_LSB +: 2];
    v[usb_ep_cfg_pkg::VALID_BIT] = wr[usb_ep_cfg_pkg::VALID_BIT];
    if (s < 3'h2) begin
      v[usb_ep_cfg_pkg::TYPE_LSB +: 2] = // RL7
          (t == usb_ep_cfg_pkg::TYPE_BULK || t == usb_ep_cfg_pkg::TYPE_INT)
          ? t : old[usb_ep_cfg_pkg::TYPE_LSB +: 2];
    end else begin
      v[usb_ep_cfg_pkg::TYPE_LSB +: 2] = t; // RL13
      v[usb_ep_cfg_pkg::DIR_BIT] = wr[usb_ep_cfg_pkg::DIR_BIT]; // RL14
      if (s == 3'h2 || s == 3'h4) begin
        v[usb_ep_cfg_pkg::SIZE_BIT] = wr[usb_ep_cfg_pkg::SIZE_BIT]; // RL10
        v[usb_ep_cfg_pkg::BUF_LSB +: 2] = // RL15
            (b == usb_ep_cfg_pkg::BUF_INVALID)
            ? old[usb_ep_cfg_pkg::BUF_LSB +: 2] : b;
      end
    end
    return v;
  endfunction

  function automatic logic [2:0] buf_depth(input logic [1:0] b);
    case (b)
      usb_ep_cfg_pkg::BUF_QUAD: return usb_ep_cfg_pkg::DEPTH_FOUR; // RL15
      usb_ep_cfg_pkg::BUF_TRIPLE: return usb_ep_cfg_pkg::DEPTH_THREE;
      default: return usb_ep_cfg_pkg::DEPTH_TWO;
    endcase
  endfunction

  // Largest payload the transfer type allows at the current speed
  function automatic logic [10:0] type_limit(input logic [1:0] t,
      input logic hs);
    if (t == usb_ep_cfg_pkg::TYPE_ISO) begin
      return hs ? usb_ep_cfg_pkg::SIZE_1024 : usb_ep_cfg_pkg::SIZE_1023;
    end else if (!hs) begin
      return usb_ep_cfg_pkg::SIZE_64;
    end else if (t == usb_ep_cfg_pkg::TYPE_INT) begin
      return usb_ep_cfg_pkg::SIZE_1024;
    end else begin
      return usb_ep_cfg_pkg::SIZE_512;
    end
  endfunction

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r[0] <= usb_ep_cfg_pkg::RST_SMALL_CFG; // RL12
      cfg_r[1] <= usb_ep_cfg_pkg::RST_SMALL_CFG;
      for (int k = 2; k < usb_ep_cfg_pkg::NUM_CFG; k++) begin
        cfg_r[k] <= usb_ep_cfg_pkg::RST_LARGE_CFG;
      end
    end else if (take && we_i && sel_i[0] && cfg_slot(idx) != 3'h7) begin
      cfg_r[cfg_slot(idx)] <= clean_cfg(cfg_slot(idx), // RL6
          cfg_r[cfg_slot(idx)], dat_i[7:0]);
    end
  end

  // Buffer pointer; auto window steps it, block window leaves it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= usb_ep_cfg_pkg::RST_BUF_PTR;
    end else if (take && idx == usb_ep_cfg_pkg::IDX_BUF_PTR && we_i) begin
      if (sel_i[0]) begin
        ptr_r[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        ptr_r[15:8] <= dat_i[15:8];
      end
    end else if (take && idx == usb_ep_cfg_pkg::IDX_BUF_AUTO &&
        (!we_i || sel_i[0])) begin
      ptr_r <= ptr_r + 16'h0001; // RL3
    end
  end

  // Buffer RAM strobes, one cycle each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_we_o <= 1'b0;
      buf_re_o <= 1'b0;
      buf_addr_o <= '0;
      buf_wdata_o <= '0;
    end else begin
      buf_we_o <= 1'b0;
      buf_re_o <= 1'b0;
      if (take && (idx == usb_ep_cfg_pkg::IDX_BUF_AUTO ||
          idx == usb_ep_cfg_pkg::IDX_BUF_BLOCK)) begin
        buf_addr_o <= ptr_r; // RL3
        buf_wdata_o <= dat_i[7:0];
        buf_we_o <= we_i && sel_i[0];
        buf_re_o <= !we_i;
      end
    end
  end

  // Bus answer: ack three edges after the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_r <= 1'b0;
      wait_r <= 1'b0;
      ack_o <= 1'b0;
      idx_r <= '0;
      data_rd_r <= 1'b0;
    end else begin
      req_r <= take;
      wait_r <= req_r;
      ack_o <= wait_r;
      if (take) begin
        idx_r <= idx;
        data_rd_r <= !we_i && (idx == usb_ep_cfg_pkg::IDX_BUF_AUTO ||
            idx == usb_ep_cfg_pkg::IDX_BUF_BLOCK);
      end
    end
  end

  // Register read mux, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rd_r <= '0;
    end else if (req_r) begin
      if (cfg_slot(idx_r) != 3'h7) begin
        reg_rd_r <= cfg_r[cfg_slot(idx_r)];
      end else if (idx_r == usb_ep_cfg_pkg::IDX_STATUS) begin
        reg_rd_r <= {high_speed_i, 1'b0, enabled};
      end else begin
        reg_rd_r <= '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (wait_r) begin
      if (idx_r == usb_ep_cfg_pkg::IDX_BUF_PTR) begin
        dat_o <= {16'h0000, ptr_r};
      end else if (data_rd_r) begin
        dat_o <= {24'h000000, buf_rdata_i};
      end else begin
        dat_o <= {24'h000000, reg_rd_r};
      end
    end
  end

  // Effective depth and size of each endpoint
  always_comb begin
    bsize[0] = usb_ep_cfg_pkg::SIZE_64; // RL7
    bsize[1] = usb_ep_cfg_pkg::SIZE_64; // RL1
    for (int k = 0; k < 4; k++) begin
      logic iso;
      logic flex;
      logic big;
      iso = cfg_r[k+2][usb_ep_cfg_pkg::TYPE_LSB +: 2] ==
          usb_ep_cfg_pkg::TYPE_ISO;
      flex = (k == 0) || (k == 2);
      big = flex && cfg_r[k+2][usb_ep_cfg_pkg::SIZE_BIT];
      depth[k] = flex ? buf_depth(cfg_r[k+2][usb_ep_cfg_pkg::BUF_LSB +: 2])
          : usb_ep_cfg_pkg::DEPTH_TWO; // RL11
      if (!high_speed_i && !iso) begin
        bsize[k+2] = usb_ep_cfg_pkg::SIZE_64; // RL5
      end else begin
        bsize[k+2] = big ? usb_ep_cfg_pkg::SIZE_1024 // RL10
            : usb_ep_cfg_pkg::SIZE_512;
      end
      large_in[k] = cfg_r[k+2][usb_ep_cfg_pkg::DIR_BIT]; // RL14
    end
  end

  // Deep or wide buffering on 2 and 6 takes the RAM of their neighbours
  assign cons_four = depth[0] > usb_ep_cfg_pkg::DEPTH_TWO ||
      cfg_r[2][usb_ep_cfg_pkg::SIZE_BIT]; // RL16
  assign cons_six = depth[0] > usb_ep_cfg_pkg::DEPTH_TWO &&
      cfg_r[2][usb_ep_cfg_pkg::SIZE_BIT]; // RL16
  assign cons_eight = cons_six || depth[2] > usb_ep_cfg_pkg::DEPTH_TWO ||
      cfg_r[4][usb_ep_cfg_pkg::SIZE_BIT]; // RL16

  always_comb begin
    for (int k = 0; k < usb_ep_cfg_pkg::NUM_CFG; k++) begin
      enabled[k] = cfg_r[k][usb_ep_cfg_pkg::VALID_BIT] && // RL12
          cfg_r[k][usb_ep_cfg_pkg::TYPE_LSB +: 2] !=
          usb_ep_cfg_pkg::TYPE_INVALID; // RL13
    end
    if (cons_four) begin
      enabled[3] = 1'b0; // RL16
    end
    if (cons_six) begin
      enabled[4] = 1'b0; // RL16
    end
    if (cons_eight) begin
      enabled[5] = 1'b0; // RL16
    end
  end

  // A configuration change empties the endpoint's buffers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < 4; k++) begin
        cfg_prev[k] <= usb_ep_cfg_pkg::RST_LARGE_CFG;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        cfg_prev[k] <= cfg_r[k+2];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : large_ep
      assign flush[g] = cfg_prev[g] != cfg_r[g+2] || !enabled[g+2];
      ep_buf_tracker #(
        .DEPTH_W(3)
      ) tracker (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .depth_i(depth[g]),
        .dir_in_i(large_in[g]),
        .flush_i(flush[g]),
        .usb_done_i(usb_done_i[g]),
        .ext_done_i(ext_done_i[g] && enabled[g+2]), // RL2
        .usb_ready_o(usb_ready[g]),
        .ext_ready_o(ext_ready_o[g]),
        .occ_o()
      );
    end
  endgenerate

  // Only large endpoints are offered to external logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_enable_o <= '0;
    end else begin
      ext_enable_o <= enabled[5:2]; // RL2
    end
  end

  // Large endpoint slot 0..3 of the token, and its payload limit
  assign tok_n = token_ep_i[2:1] - 2'h1;
  assign tok_t = cfg_r[3'(tok_n) + 3'h2][usb_ep_cfg_pkg::TYPE_LSB +: 2];
  assign tok_lim = type_limit(tok_t, high_speed_i) < bsize[3'(tok_n) + 3'h2]
      ? type_limit(tok_t, high_speed_i) : bsize[3'(tok_n) + 3'h2];

  // Token decision, one cycle after the token pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      answer_o <= 1'b0;
      ready_o <= 1'b0;
      len_ok_o <= 1'b0;
    end else begin
      answer_o <= 1'b0;
      ready_o <= 1'b0;
      len_ok_o <= 1'b0;
      if (token_i) begin
        case (token_ep_i)
          4'h0: begin
            answer_o <= 1'b1; // RL9
            ready_o <= 1'b1;
            len_ok_o <= token_len_i <= usb_ep_cfg_pkg::SIZE_64; // RL9
          end
          4'h1: begin
            answer_o <= enabled[token_in_i]; // RL12
            ready_o <= enabled[token_in_i];
            len_ok_o <= enabled[token_in_i] && // RL8
                token_len_i <= bsize[token_in_i];
          end
          4'h2, 4'h4, 4'h6, 4'h8: begin
            answer_o <= enabled[3'(tok_n) + 3'h2] &&
                large_in[tok_n] == token_in_i;
            ready_o <= enabled[3'(tok_n) + 3'h2] &&
                large_in[tok_n] == token_in_i && usb_ready[tok_n]; // RL17
            len_ok_o <= enabled[3'(tok_n) + 3'h2] && // RL4
                token_len_i <= tok_lim &&
                (tok_t == usb_ep_cfg_pkg::TYPE_BULK || token_len_i != '0);
          end
          default: answer_o <= 1'b0;
        endcase
      end
    end
  end
endmodule

// >>> usb_endpoint_config_bank_tb_top.sv
/* Self-checking bench for the endpoint configuration bank.
   Assumes the bank answers bus requests after three edges. */
module usb_endpoint_config_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, high_speed_i = 1'b1;
  logic token_i = 1'b0, token_in_i = 1'b0, tk_d = 1'b0;
  logic [17:0] adr_i = 18'h00000;
  logic [3:0] sel_i = 4'h0, token_ep_i = 4'h0, usb_done_i = 4'h0;
  logic [3:0] move = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic [10:0] token_len_i = 11'h000;
  logic [31:0] dat_o;
  logic ack_o, answer_o, ready_o, len_ok_o, buf_we_o, buf_re_o;
  logic [3:0] ext_ready_o, ext_enable_o, ext_done_i;
  logic [15:0] buf_addr_o;
  logic [7:0] buf_wdata_o, buf_rdata_i;
  int err_count = 0, comparisons = 0, cycles = 0;
  logic [31:0] rd_q[$];
  logic [5:0] tk_q[$];

  usb_endpoint_config_bank i_usb_endpoint_config_bank (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .high_speed_i(high_speed_i), .token_i(token_i),
    .token_ep_i(token_ep_i), .token_in_i(token_in_i),
    .token_len_i(token_len_i), .answer_o(answer_o), .ready_o(ready_o),
    .len_ok_o(len_ok_o), .usb_done_i(usb_done_i), .ext_done_i(ext_done_i),
    .ext_ready_o(ext_ready_o), .ext_enable_o(ext_enable_o),
    .buf_addr_o(buf_addr_o), .buf_wdata_o(buf_wdata_o),
    .buf_we_o(buf_we_o), .buf_re_o(buf_re_o), .buf_rdata_i(buf_rdata_i));
  usb_far_side_model i_usb_far_side_model (.clk_i(clk_i), .rst_i(rst_i),
    .buf_addr_i(buf_addr_o), .buf_wdata_i(buf_wdata_o),
    .buf_we_i(buf_we_o), .buf_re_i(buf_re_o), .buf_rdata_o(buf_rdata_i),
    .move_i(move), .ext_ready_i(ext_ready_o), .ext_done_o(ext_done_i));

  always #12.5 clk_i = ~clk_i;

  task automatic bad(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) bad("read data mismatch");
  endtask
  task automatic chk_tok(input logic [5:0] e, input logic [2:0] g);
    comparisons++;
    if ((g & e[5:3]) !== (e[2:0] & e[5:3])) bad("token answer mismatch");
  endtask
  task automatic chk_level(input logic e, input logic g);
    comparisons++;
    if (g !== e) bad("ready level mismatch");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Results are judged where they appear, against notes left by drivers
  always @(posedge clk_i) begin
    if (tk_d && tk_q.size() > 0)
      chk_tok(tk_q.pop_front(), {answer_o, ready_o, len_ok_o});
    if (ack_o === 1'b1 && !we_i && rd_q.size() > 0)
      chk_data(rd_q.pop_front(), dat_o);
    tk_d = token_i;
    cycles++;
    if (cycles > 20000) begin
      bad("timeout");
      tally_and_finish();
    end
  end

  task automatic wb(input logic w, input logic [15:0] i, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {i, 2'b00};
    sel_i <= 4'hf;
    dat_i <= d;
    // Only ack or the bench timeout ends this wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    wb(1'b1, i, {24'h000000, d});
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, i, 32'h00000000);
  endtask
  // Expected is {care mask, answer ready len_ok}
  task automatic tok(input logic [3:0] ep, input logic din,
    input logic [10:0] len, input logic [5:0] e);
    @(posedge clk_i);
    token_i <= 1'b1;
    token_ep_i <= ep;
    token_in_i <= din;
    token_len_i <= len;
    tk_q.push_back(e);
    @(posedge clk_i);
    token_i <= 1'b0;
  endtask
  task automatic usb_pkt;
    @(posedge clk_i);
    usb_done_i <= 4'h1;
    @(posedge clk_i);
    usb_done_i <= 4'h0;
  endtask

  initial begin
    logic [7:0] v;
    void'($urandom(24361));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(16'he610 + 16'(i), i < 2 ? 8'ha0 : 8'ha2);
    rd(16'he630, 32'h0);
    rd(16'he623, 32'hbf);
    $display("test reset_values done");
    wr(16'he610, 8'h80);
    rd(16'he610, 32'ha0);
    wr(16'he610, 8'hb0);
    rd(16'he610, 32'hb0);
    wr(16'he610, 8'ha0);
    for (int b = 0; b < 4; b++) begin
      wr(16'he612, 8'ha0 | 8'(b));
      rd(16'he612, b == 1 ? 8'ha0 : 8'ha0 | 8'(b));
    end
    wr(16'he612, 8'ha2);
    for (int t = 0; t < 4; t++) begin
      v = {1'b1, 1'($urandom), 2'(t), 4'h0};
      wr(16'he613, v);
      rd(16'he613, {24'h0, v});
      rd(16'he623, t != 0 ? 8'hbf : 8'hb7);
    end
    wr(16'he613, 8'ha2);
    $display("test fields done");
    tok(4'h0, 1'b1, 11'd64, 6'o77);
    tok(4'h0, 1'b0, 11'd65, 6'o76);
    tok(4'h3, 1'b0, 11'd8, 6'o70);
    tok(4'h1, 1'b0, 11'd64, 6'o77);
    tok(4'h1, 1'b1, 11'd65, 6'o76);
    tok(4'h2, 1'b0, 11'd512, 6'o77);
    tok(4'h2, 1'b0, 11'd513, 6'o76);
    wr(16'he612, 8'hba);
    tok(4'h2, 1'b0, 11'd1024, 6'o77);
    tok(4'h2, 1'b0, 11'd0, 6'o76);
    tok(4'h2, 1'b0, 11'd1025, 6'o76);
    wr(16'he612, 8'haa);
    tok(4'h2, 1'b0, 11'd513, 6'o76);
    rd(16'he623, 32'hb7);
    high_speed_i <= 1'b0;
    wr(16'he612, 8'ha2);
    tok(4'h2, 1'b0, 11'(1 + $urandom % 64), 6'o77);
    tok(4'h2, 1'b0, 11'd65, 6'o76);
    wr(16'he612, 8'h9a);
    tok(4'h2, 1'b0, 11'd1023, 6'o77);
    tok(4'h2, 1'b0, 11'd1024, 6'o76);
    wr(16'he612, 8'h22);
    tok(4'h2, 1'b0, 11'd8, 6'o40);
    rd(16'he623, 32'h3b);
    high_speed_i <= 1'b1;
    $display("test tokens done");
    wr(16'he612, 8'he2);
    repeat (2) @(posedge clk_i);
    chk_level(1'b1, ext_ready_o[0]);
    move <= 4'h1;
    repeat (8) @(posedge clk_i);
    move <= 4'h0;
    chk_level(1'b0, ext_ready_o[0]);
    tok(4'h2, 1'b1, 11'd64, 6'o77);
    tok(4'h2, 1'b0, 11'd64, 6'o40);
    usb_pkt();
    usb_pkt();
    repeat (2) @(posedge clk_i);
    tok(4'h2, 1'b1, 11'd64, 6'o75);
    chk_level(1'b1, ext_ready_o[0]);
    $display("test buffering done");
    v = 8'($urandom);
    wr(16'he620, 8'h10);
    wr(16'he621, v);
    wr(16'he621, 8'h6b);
    rd(16'he620, 32'h12);
    wr(16'he620, 8'h10);
    rd(16'he622, {24'h0, v});
    rd(16'he621, {24'h0, v});
    rd(16'he621, 32'h6b);
    repeat (4) @(posedge clk_i);
    $display("test data_window done");
    tally_and_finish();
  end
endmodule

// >>> usb_ep_cfg_monitor.sv
/* Port checker for the endpoint configuration bank.
   Assumes a classic Wishbone master that drops stb after each ack. */
module usb_ep_cfg_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic buf_we_o,
  input wire logic buf_re_o,
  // Host token
  input wire logic token_i,
  input wire logic [3:0] token_ep_i,
  input wire logic [10:0] token_len_i,
  input wire logic answer_o,
  input wire logic ready_o,
  input wire logic len_ok_o,
  input wire logic [3:0] ext_enable_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence req_start;
    cyc_i && stb_i && $rose(stb_i);
  endsequence
  sequence ack_on_third;
    !ack_o ##1 !ack_o ##1 !ack_o ##1 ack_o;
  endsequence
  sequence any_answer;
    answer_o || ready_o || len_ok_o;
  endsequence

  chk_ack_latency: assert property (req_start |-> ack_on_third)
    else $error("ack not on third edge");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_buf_strobe: assert property ((buf_we_o || buf_re_o) |=>
    !buf_we_o && !buf_re_o)
    else $error("buffer strobe held");
  chk_answer_cause: assert property (any_answer |-> $past(token_i))
    else $error("answer without token");
  chk_ep0_fixed: assert property (token_i && token_ep_i == 4'h0 &&
    token_len_i <= 11'h040 |=> answer_o && ready_o && len_ok_o)
    else $error("endpoint zero refused");
  chk_small_limit: assert property (token_i && token_ep_i <= 4'h1 &&
    token_len_i > 11'h040 |=> !len_ok_o)
    else $error("small endpoint over 64");
  chk_bad_ep: assert property (token_i && !(token_ep_i inside
    {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8}) |=> !answer_o && !ready_o &&
    !len_ok_o)
    else $error("unknown endpoint answered");
  chk_disabled_mute: assert property (token_i && token_ep_i == 4'h2 |=>
    ext_enable_o[0] || !answer_o)
    else $error("disabled endpoint answered");
  chk_large_limit: assert property (token_i && token_ep_i[0] == 1'b0 &&
    token_ep_i != 4'h0 && token_len_i > 11'h400 |=> !len_ok_o)
    else $error("payload over 1024 accepted");
endmodule

bind usb_endpoint_config_bank usb_ep_cfg_monitor i_usb_ep_cfg_monitor (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .buf_we_o, .buf_re_o, .token_i,
  .token_ep_i, .token_len_i, .answer_o, .ready_o, .len_ok_o, .ext_enable_o
);

// >>> usb_ep_cfg_pkg.sv
/*
 * Constants for the endpoint configuration bank: register indices, field
 * positions, reset values, encodings and packet size limits.
 * Assumes a 32-bit Wishbone bus; byte address is four times the index.
 */
package usb_ep_cfg_pkg;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned NUM_CFG = 6;
  // Register indices
  localparam logic [15:0] IDX_EP1_OUT = 16'he610;
  localparam logic [15:0] IDX_EP1_IN = 16'he611;
  localparam logic [15:0] IDX_EP_TWO = 16'he612;
  localparam logic [15:0] IDX_EP_FOUR = 16'he613;
  localparam logic [15:0] IDX_EP_SIX = 16'he614;
  localparam logic [15:0] IDX_EP_EIGHT = 16'he615;
  localparam logic [15:0] IDX_BUF_PTR = 16'he620;
  localparam logic [15:0] IDX_BUF_AUTO = 16'he621;
  localparam logic [15:0] IDX_BUF_BLOCK = 16'he622;
  localparam logic [15:0] IDX_STATUS = 16'he623;
  // Field positions
  localparam int unsigned VALID_BIT = 7;
  localparam int unsigned DIR_BIT = 6;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned SIZE_BIT = 3;
  localparam int unsigned BUF_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_SMALL_CFG = 8'ha0;
  localparam logic [7:0] RST_LARGE_CFG = 8'ha2;
  localparam logic [15:0] RST_BUF_PTR = 16'h0000;
  // Endpoint type encodings
  localparam logic [1:0] TYPE_INVALID = 2'h0;
  localparam logic [1:0] TYPE_ISO = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INT = 2'h3;
  // Buffering depth encodings
  localparam logic [1:0] BUF_QUAD = 2'h0;
  localparam logic [1:0] BUF_INVALID = 2'h1;
  localparam logic [1:0] BUF_DOUBLE = 2'h2;
  localparam logic [1:0] BUF_TRIPLE = 2'h3;
  localparam logic [2:0] DEPTH_ONE = 3'h1;
  localparam logic [2:0] DEPTH_TWO = 3'h2;
  localparam logic [2:0] DEPTH_THREE = 3'h3;
  localparam logic [2:0] DEPTH_FOUR = 3'h4;
  // Sizes in bytes
  localparam logic [10:0] SIZE_64 = 11'h040;
  localparam logic [10:0] SIZE_512 = 11'h200;
  localparam logic [10:0] SIZE_1023 = 11'h3ff;
  localparam logic [10:0] SIZE_1024 = 11'h400;
endpackage

// >>> usb_far_side_model.sv
/* Far side model: endpoint buffer RAM and external FIFO logic.
   Assumes the bank clock; move requests come from the bench. */
module usb_far_side_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Buffer RAM port
  input wire logic [15:0] buf_addr_i,
  input wire logic [7:0] buf_wdata_i,
  input wire logic buf_we_i,
  input wire logic buf_re_i,
  output logic [7:0] buf_rdata_o,
  // External FIFO side
  input wire logic [3:0] move_i,
  input wire logic [3:0] ext_ready_i,
  output logic [3:0] ext_done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:255];

  // Data only valid after a read; toggles otherwise so stale use shows
  always_ff @(posedge clk_i) begin
    if (buf_we_i) mem[buf_addr_i[7:0]] <= buf_wdata_i;
    if (rst_i) buf_rdata_o <= 8'h00;
    else buf_rdata_o <= buf_re_i ? mem[buf_addr_i[7:0]] : ~buf_rdata_o;
  end

  // One packet per free buffer, never into a full endpoint
  always_ff @(posedge clk_i) begin
    if (rst_i) ext_done_o <= 4'h0;
    else ext_done_o <= move_i & ext_ready_i & ~ext_done_o;
  end
endmodule
